// File: inc/cogen_pkg.sv
/*
 * Constants for the complementary output generator: register map,
 * field positions, reset values, mode codes and clock figures.
 * Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package cogen_pkg;
    // ************************************************
    // Clock figures
    // ************************************************
    localparam int CLK_MHZ = 20;
    localparam int OSC_MHZ = 8;
    localparam int DIV4 = 4;

    // ************************************************
    // Register byte offsets
    // ************************************************
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_RISE_EN = 6'h04;
    localparam logic [5:0] OFS_RISE_SIM = 6'h08;
    localparam logic [5:0] OFS_FALL_EN = 6'h0C;
    localparam logic [5:0] OFS_FALL_SIM = 6'h10;
    localparam logic [5:0] OFS_STEER = 6'h14;
    localparam logic [5:0] OFS_DB_RISE = 6'h18;
    localparam logic [5:0] OFS_DB_FALL = 6'h1C;
    localparam logic [5:0] OFS_BLK_RISE = 6'h20;
    localparam logic [5:0] OFS_BLK_FALL = 6'h24;
    localparam logic [5:0] OFS_PH_RISE = 6'h28;
    localparam logic [5:0] OFS_PH_FALL = 6'h2C;
    localparam logic [5:0] OFS_STATUS = 6'h30;
    localparam int NREG = 12;

    // ************************************************
    // Fields and reset values
    // ************************************************
    localparam int CTRL_EN = 7;
    localparam int CTRL_CS_LO = 3;
    localparam int STEER_DAT_LO = 4;
    localparam int NSRC = 4;
    localparam logic [7:0] REG_RST = 8'h00;

    typedef enum logic [2:0] {
        MD_STEER = 3'h0,
        MD_SYNC = 3'h1,
        MD_FWD = 3'h2,
        MD_REV = 3'h3,
        MD_HALF = 3'h4,
        MD_PP = 3'h5,
        MD_RSV6 = 3'h6,
        MD_RSV7 = 3'h7
    } cogen_mode_e;

    localparam logic [1:0] CS_OSC = 2'h0;
    localparam logic [1:0] CS_DIV4 = 2'h1;
    localparam logic [1:0] CS_SYS = 2'h2;
endpackage : cogen_pkg

// File: core/cogen_top.sv
/*
 * Complementary output generator: event sensing, phase delay,
 * blanking and dead-band timers, mode logic and a register slave.
 * Assumes event sources are synchronous to ref_clk and an Avalon-MM
 * master that holds each request until waitrequest is seen low.
 */
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps

// ************************************************
// Reusable tick-based delay timer
// ************************************************
module cogen_timer (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic [7:0] val,
    output logic busy,
    output logic done
);
    logic [7:0] cnt;
    logic [7:0] cntInc;

    assign cntInc = 8'(cnt + 8'h01);

    // Zero value finishes in the start cycle, so delays can be bypassed
    assign done = !abort && (start ? (val == 8'h00)
                                   : (busy && tick && cntInc == val));

    // Count ticks from zero up to the programmed value
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
        end else if (abort) begin
            busy <= 1'b0;
        end else if (start) begin
            busy <= (val != 8'h00);
            cnt <= 8'h00;
        end else if (busy && tick) begin
            cnt <= cntInc;
            if (cntInc == val) begin
                busy <= 1'b0;
            end
        end
    end
endmodule : cogen_timer

// ************************************************
// Top level
// ************************************************
module cogen_top
    import cogen_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [NSRC-1:0] riseSrc,
    input wire logic [NSRC-1:0] fallSrc,
    output logic driveOutA,
    output logic driveOutB,
    output logic driveOutC,
    output logic driveOutD
);
    logic [7:0] cfg [NREG];
    logic [3:0] regIdx;
    logic regHit;
    logic busReq;
    logic doWrite;
    logic [7:0] statusVal;
    logic en;
    cogen_mode_e md;
    logic [1:0] cs;

    // ************************************************
    // Register slave
    // ************************************************
    assign regIdx = address[5:2];
    assign regHit = (address[1:0] == 2'h0) && (int'(regIdx) < NREG);
    assign busReq = read || write;
    assign doWrite = write && !waitrequest && regHit && byteenable[0];

    // One wait state, then the answer edge; idle level is high
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !(busReq && waitrequest);
        end
    end

    // Read data is captured one edge before the answer edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            if (address == OFS_STATUS) begin
                readdata <= {24'h00_0000, statusVal};
            end else if (regHit) begin
                readdata <= {24'h00_0000, cfg[regIdx]};
            end else begin
                readdata <= 32'h0000_0000;
            end
        end
    end

    // Configuration storage, written only in the low byte lane
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NREG; i++) begin
                cfg[i] <= REG_RST;
            end
        end else if (doWrite) begin
            cfg[regIdx] <= writedata[7:0];
        end
    end

    assign en = cfg[OFS_CTRL[5:2]][CTRL_EN];
    assign md = cogen_mode_e'(cfg[OFS_CTRL[5:2]][2:0]);
    assign cs = cfg[OFS_CTRL[5:2]][CTRL_CS_LO +: 2];

    // ************************************************
    // Generator timing clock
    // ************************************************
    logic tick;
    logic [4:0] oscAcc;
    logic [1:0] divCnt;
    logic [5:0] oscSum;

    assign oscSum = 6'(oscAcc + 5'(OSC_MHZ));

    // 8 MHz rate made from 20 MHz by a fractional accumulator
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oscAcc <= 5'h00;
        end else if (oscSum >= 6'(CLK_MHZ)) begin
            oscAcc <= 5'(oscSum - 6'(CLK_MHZ));
        end else begin
            oscAcc <= oscSum[4:0];
        end
    end

    // Quarter-rate divider for the instruction clock
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            divCnt <= 2'h0;
        end else begin
            divCnt <= 2'(divCnt + 2'h1);
        end
    end

    // Code 3 is unused and falls back to the system clock
    always_comb begin
        unique case (cs)
            CS_OSC: tick = (oscSum >= 6'(CLK_MHZ));
            CS_DIV4: tick = (divCnt == 2'(DIV4 - 1));
            default: tick = 1'b1;
        endcase
    end

    // ************************************************
    // Event sensing
    // ************************************************
    logic [NSRC-1:0] riseQ;
    logic [NSRC-1:0] fallQ;
    logic riseComb;
    logic fallComb;
    logic riseCombQ;
    logic fallCombQ;
    logic riseEvt;
    logic fallEvt;
    logic blkRBusy;
    logic blkFBusy;

    // Edge mode passes only the change; level mode passes the level
    // Sense bits act per source, so the mask is applied bit by bit
    assign riseComb = |(cfg[OFS_RISE_EN[5:2]][NSRC-1:0] & riseSrc
        & ~(cfg[OFS_RISE_SIM[5:2]][NSRC-1:0] & riseQ));
    assign fallComb = |(cfg[OFS_FALL_EN[5:2]][NSRC-1:0] & fallSrc
        & ~(cfg[OFS_FALL_SIM[5:2]][NSRC-1:0] & fallQ));

    // Per-source and per-group history for edge detection
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            riseQ <= '0;
            fallQ <= '0;
            riseCombQ <= 1'b0;
            fallCombQ <= 1'b0;
        end else begin
            riseQ <= riseSrc;
            fallQ <= fallSrc;
            riseCombQ <= riseComb;
            fallCombQ <= fallComb;
        end
    end

    // Rise group fires on its low-to-high change, fall group on its
    // high-to-low change; a simultaneous rise wins so drive never sticks off
    assign riseEvt = en && riseComb && !riseCombQ && !blkFBusy;
    assign fallEvt = en && !fallComb && fallCombQ && !blkRBusy && !riseEvt;

    // ************************************************
    // Phase delay, blanking and dead-band timers
    // ************************************************
    logic phRDone;
    logic phFDone;
    logic dbRDone;
    logic dbFDone;
    logic dirBusy;
    logic dirStart;
    logic [7:0] dirVal;

    cogen_timer phRise (.ref_clk(ref_clk), .nrst(nrst), .tick(tick),
        .start(riseEvt), .abort(fallEvt || !en),
        .val(cfg[OFS_PH_RISE[5:2]]), .busy(), .done(phRDone));
    cogen_timer dbRise (.ref_clk(ref_clk), .nrst(nrst), .tick(tick),
        .start(phRDone), .abort(fallEvt || !en),
        .val(cfg[OFS_DB_RISE[5:2]]), .busy(), .done(dbRDone));
    cogen_timer blkRise (.ref_clk(ref_clk), .nrst(nrst), .tick(tick),
        .start(phRDone), .abort(!en),
        .val(cfg[OFS_BLK_RISE[5:2]]), .busy(blkRBusy), .done());
    cogen_timer phFall (.ref_clk(ref_clk), .nrst(nrst), .tick(tick),
        .start(fallEvt), .abort(riseEvt || !en),
        .val(cfg[OFS_PH_FALL[5:2]]), .busy(), .done(phFDone));
    cogen_timer dbFall (.ref_clk(ref_clk), .nrst(nrst), .tick(tick),
        .start(phFDone), .abort(riseEvt || !en),
        .val(cfg[OFS_DB_FALL[5:2]]), .busy(), .done(dbFDone));
    cogen_timer blkFall (.ref_clk(ref_clk), .nrst(nrst), .tick(tick),
        .start(fallEvt), .abort(!en),
        .val(cfg[OFS_BLK_FALL[5:2]]), .busy(blkFBusy), .done());
    cogen_timer dirHold (.ref_clk(ref_clk), .nrst(nrst), .tick(tick),
        .start(dirStart), .abort(!en),
        .val(dirVal), .busy(dirBusy), .done());

    // ************************************************
    // Primary and complementary sequencing
    // ************************************************
    logic primOn;
    logic compOn;

    // Disabled state parks primary low and complement high
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            primOn <= 1'b0;
            compOn <= 1'b1;
        end else if (!en) begin
            primOn <= 1'b0;
            compOn <= 1'b1;
        end else begin
            if (phRDone) begin
                compOn <= 1'b0;
            end else if (dbFDone) begin
                compOn <= 1'b1;
            end
            if (fallEvt) begin
                primOn <= 1'b0;
            end else if (dbRDone) begin
                primOn <= 1'b1;
            end
        end
    end

    // ************************************************
    // Steering, push-pull phase and direction tracking
    // ************************************************
    logic [3:0] strSync;
    logic [3:0] strEff;
    logic ppPh;
    logic lastRev;
    logic fbSeen;
    logic isFb;

    // Synchronous steering waits for a rising event
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            strSync <= 4'h0;
        end else if (md != MD_SYNC || riseEvt) begin
            strSync <= cfg[OFS_STEER[5:2]][3:0];
        end
    end
    assign strEff = (md == MD_SYNC) ? strSync : cfg[OFS_STEER[5:2]][3:0];

    // Each rising event hands the period to the other pair
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ppPh <= 1'b0;
        end else if (!en) begin
            ppPh <= 1'b0;
        end else if (riseEvt && md == MD_PP) begin
            ppPh <= !ppPh;
        end
    end

    assign isFb = en && (md == MD_FWD || md == MD_REV);
    assign dirStart = isFb && fbSeen && (lastRev != (md == MD_REV));
    // Forward to reverse uses falling dead time, the other way rising
    assign dirVal = (md == MD_REV) ? cfg[OFS_DB_FALL[5:2]] : cfg[OFS_DB_RISE[5:2]];

    // Remember the last full-bridge direction
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lastRev <= 1'b0;
            fbSeen <= 1'b0;
        end else if (isFb) begin
            lastRev <= (md == MD_REV);
            fbSeen <= 1'b1;
        end else if (!en) begin
            fbSeen <= 1'b0;
        end
    end

    // ************************************************
    // Output mode mux
    // ************************************************
    logic [3:0] next_drive;
    logic [3:0] sdat;
    logic [3:0] safe;

    assign sdat = cfg[OFS_STEER[5:2]][STEER_DAT_LO +: 4];

    // Bits are {D, C, B, A}
    always_comb begin
        next_drive = 4'h0;
        if (!en) begin
            next_drive = {compOn, primOn, compOn, primOn};
        end else begin
            unique case (md)
                MD_STEER, MD_SYNC: begin
                    next_drive = (strEff & {4{primOn}}) | (~strEff & sdat);
                end
                MD_FWD: begin
                    next_drive = {primOn && !dirBusy, 1'b0, 1'b0, 1'b1};
                end
                MD_REV: begin
                    next_drive = {1'b0, 1'b1, primOn && !dirBusy, 1'b0};
                end
                MD_HALF: begin
                    next_drive = (strEff & {compOn, primOn, compOn, primOn})
                        | (~strEff & sdat);
                end
                MD_PP: begin
                    next_drive = {primOn && !ppPh, primOn && ppPh,
                        primOn && !ppPh, primOn && ppPh};
                end
                default: begin
                    next_drive = 4'h0;
                end
            endcase
        end
    end

    // A conflicting leg is turned fully off rather than shorted
    assign safe = {next_drive[3] && !next_drive[2], next_drive[2] && !next_drive[3],
        next_drive[1] && !next_drive[0], next_drive[0] && !next_drive[1]};

    // Registered pins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            driveOutA <= 1'b0;
            driveOutB <= 1'b0;
            driveOutC <= 1'b0;
            driveOutD <= 1'b0;
        end else begin
            driveOutA <= safe[0];
            driveOutB <= safe[1];
            driveOutC <= safe[2];
            driveOutD <= safe[3];
        end
    end

    assign statusVal = {dirBusy, ppPh, compOn, primOn,
        driveOutD, driveOutC, driveOutB, driveOutA};

    // ************************************************
    // Checks
    // ************************************************
    fwdDrive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (en && md == MD_FWD) ##1 (en && md == MD_FWD)
        |-> driveOutA && !driveOutB && !driveOutC)
        else $error("forward bridge outputs wrong");
    revDrive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (en && md == MD_REV) ##1 (en && md == MD_REV)
        |-> driveOutC && !driveOutA && !driveOutD)
        else $error("reverse bridge outputs wrong");
    ppPairs_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (en && md == MD_PP) ##1 (en && md == MD_PP)
        |-> driveOutA == driveOutC && driveOutB == driveOutD)
        else $error("push-pull pairs differ");
    ppAlternate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (riseEvt && md == MD_PP) |=> ppPh != $past(ppPh))
        else $error("push-pull pair did not swap");
    legSafe_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(driveOutA && driveOutB) && !(driveOutC && driveOutD))
        else $error("leg shoot-through");
    disabled_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !en |=> !primOn && compOn)
        else $error("disabled state wrong");
    fallClear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        fallEvt |=> !primOn)
        else $error("primary not cleared on fall");
    riseNow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (riseEvt && cfg[OFS_PH_RISE[5:2]] == 8'h00 && cfg[OFS_DB_RISE[5:2]] == 8'h00)
        |=> primOn && !compOn)
        else $error("zero delay rise not immediate");
    quarterTick_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tick && cs == CS_DIV4)
        |=> (!tick || cs != CS_DIV4) ##1 (!tick || cs != CS_DIV4)
        ##1 (!tick || cs != CS_DIV4))
        else $error("quarter rate tick spacing wrong");
endmodule : cogen_top

// File: verification/cogen_src_model.sv
/*
 * Event-source partner for the complementary output generator: drives
 * the rise and fall source lines as single-cycle pulses and watches
 * the four drive outputs for a shorted half-bridge leg.
 * Assumes sources are synchronous to ref_clk, as the block expects.
 */
`timescale 1ns/1ps

module cogen_src_model
    import cogen_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    output logic [NSRC-1:0] riseSrc,
    output logic [NSRC-1:0] fallSrc,
    input wire logic driveOutA,
    input wire logic driveOutB,
    input wire logic driveOutC,
    input wire logic driveOutD,
    output int legFaults
);
    int faultCnt;

    // Lines rest low so no event is seen until a pulse is asked for
    initial begin
        riseSrc = {NSRC{1'b0}};
        fallSrc = {NSRC{1'b0}};
        faultCnt = 0;
    end

    // ************************************************
    // Source pulses
    // ************************************************
    // One cycle high, like a comparator trip or a timer match
    task automatic pulse(input bit isFall, input int idx);
        @(posedge ref_clk);
        if (isFall) begin
            fallSrc[idx] <= 1'b1;
        end else begin
            riseSrc[idx] <= 1'b1;
        end
        @(posedge ref_clk);
        riseSrc <= {NSRC{1'b0}};
        fallSrc <= {NSRC{1'b0}};
    endtask : pulse

    // ************************************************
    // Power stage watch
    // ************************************************
    // Both switches of one leg on would short the supply
    always @(posedge ref_clk) begin
        if (nrst && ((driveOutA && driveOutB) || (driveOutC && driveOutD))) begin
            faultCnt++;
        end
    end
    assign legFaults = faultCnt;
endmodule : cogen_src_model

// File: verification/cogen_top_test.sv
/*
 * Self-checking bench for the complementary output generator: register
 * access over Avalon-MM, mode outputs, event sensing and dead-band.
 * Assumes the source model drives the event lines and ref_clk is 20 MHz.
 */
`timescale 1ns/1ps

module cogen_top_test
    import cogen_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    logic [NSRC-1:0] riseSrc;
    logic [NSRC-1:0] fallSrc;
    logic driveOutA, driveOutB, driveOutC, driveOutD;
    int legFaults;
    int errors = 0;
    int cmp_count = 0;

    // ************************************************
    // Clock, design and partner
    // ************************************************
    always #25 ref_clk = ~ref_clk;

    cogen_top dut (.ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .riseSrc(riseSrc),
        .fallSrc(fallSrc), .driveOutA(driveOutA), .driveOutB(driveOutB),
        .driveOutC(driveOutC), .driveOutD(driveOutD));

    cogen_src_model src (.ref_clk(ref_clk), .nrst(nrst), .riseSrc(riseSrc),
        .fallSrc(fallSrc), .driveOutA(driveOutA), .driveOutB(driveOutB),
        .driveOutC(driveOutC), .driveOutD(driveOutD), .legFaults(legFaults));

    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic stop_test();
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // Holds the request until waitrequest is sampled low, then releases
    task automatic bus(input bit isWr, input logic [5:0] adr, input logic [7:0] dat,
            output logic [31:0] rd);
        @(posedge ref_clk);
        address <= adr;
        writedata <= {24'h000000, dat};
        read <= ~isWr;
        write <= isWr;
        do begin
            @(posedge ref_clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] adr, input logic [7:0] dat);
        logic [31:0] rd;
        bus(1'b1, adr, dat, rd);
    endtask : wr

    task automatic rdchk(input string what, input logic [5:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, adr, 8'h00, rd);
        check(what, exp, rd);
    endtask : rdchk

    // Enable bit 7, clock select 4:3, mode 2:0
    task automatic ctrl(input logic [1:0] cs, input logic [2:0] md);
        wr(OFS_CTRL, {1'b1, 2'b00, cs, md});
    endtask : ctrl

    // Pulse one source, then give the two-edge path time to land
    task automatic ev(input bit isFall, input int idx, input int waitCyc);
        src.pulse(isFall, idx);
        repeat (waitCyc) @(posedge ref_clk);
    endtask : ev

    task automatic outs(input string what, input logic [3:0] exp);
        check(what, {28'h0000000, exp}, {28'h0000000, driveOutA, driveOutB, driveOutC, driveOutD});
    endtask : outs

    // Cycles from the end of a rise pulse until output A turns on
    task automatic lag(output int n, output logic [1:0] early);
        src.pulse(1'b0, 0);
        n = 0;
        early = 2'b11;
        while (driveOutA !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
            if (n == 2) early = {driveOutA, driveOutB};
        end
    endtask : lag

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_regs();
        outs("idle outputs", 4'h5);
        rdchk("ctrl reset", OFS_CTRL, 32'h00000000);
        wr(6'h34, 8'hFF);
        rdchk("unmapped read", 6'h34, 32'h00000000);
        wr(OFS_RISE_EN, 8'h05);
        rdchk("rise enables", OFS_RISE_EN, 32'h00000005);
        wr(OFS_RISE_SIM, 8'h0F);
        wr(OFS_FALL_EN, 8'h01);
        wr(OFS_FALL_SIM, 8'h00);
        wr(OFS_STEER, 8'h0F);
    endtask : t_regs

    task automatic t_half();
        ctrl(CS_SYS, MD_HALF);
        repeat (2) @(posedge ref_clk);
        outs("half after enable", 4'h5);
        ev(1'b0, 0, 4);
        outs("half rise", 4'hA);
        ev(1'b1, 0, 4);
        outs("half fall", 4'h5);
        ev(1'b0, 1, 4);
        outs("disabled source", 4'h5);
        ev(1'b0, 2, 4);
        outs("second source", 4'hA);
        ev(1'b1, 0, 4);
        outs("half fall again", 4'h5);
        // Steer primary to A only, static D high
        wr(OFS_STEER, 8'h81);
        ev(1'b0, 0, 4);
        outs("steer A only", 4'h9);
        ev(1'b1, 0, 4);
        outs("steer static", 4'h1);
        // Synchronous steering keeps the old steer until the next rise
        wr(OFS_STEER, 8'h05);
        ctrl(CS_SYS, MD_SYNC);
        ev(1'b0, 0, 4);
        wr(OFS_STEER, 8'h01);
        repeat (3) @(posedge ref_clk);
        outs("sync steer held", 4'hA);
        ev(1'b1, 0, 4);
        ev(1'b0, 0, 4);
        outs("sync steer applied", 4'h8);
        ev(1'b1, 0, 4);
        ctrl(CS_SYS, MD_STEER);
        ev(1'b0, 0, 4);
        outs("steered rise", 4'h8);
        ev(1'b1, 0, 4);
        wr(OFS_STEER, 8'h0F);
    endtask : t_half

    task automatic t_pp();
        logic firstA;
        ctrl(CS_SYS, MD_PP);
        ev(1'b0, 0, 4);
        firstA = driveOutA;
        check("pp A equals C", {31'h0, driveOutC}, {31'h0, firstA});
        check("pp B equals D", {31'h0, driveOutD}, {31'h0, driveOutB});
        check("pp one pair", {31'h0, ~firstA}, {31'h0, driveOutB});
        ev(1'b1, 0, 4);
        outs("pp fall", 4'h0);
        ev(1'b0, 0, 4);
        check("pp pair swap", {31'h0, ~firstA}, {31'h0, driveOutA});
        check("pp swap B", {31'h0, firstA}, {31'h0, driveOutB});
        ev(1'b1, 0, 4);
    endtask : t_pp

    task automatic t_full();
        ctrl(CS_SYS, MD_FWD);
        ev(1'b0, 0, 8);
        outs("fwd rise", 4'h9);
        ev(1'b1, 0, 8);
        outs("fwd fall", 4'h8);
        ctrl(CS_SYS, MD_REV);
        ev(1'b0, 0, 8);
        outs("rev rise", 4'h6);
        ev(1'b1, 0, 8);
        outs("rev fall", 4'h2);
        // Forward to reverse holds the modulated output for fall dead time
        ctrl(CS_SYS, MD_FWD);
        wr(OFS_DB_FALL, 8'h04);
        ctrl(CS_SYS, MD_REV);
        ev(1'b0, 0, 2);
        outs("dir hold", 4'h2);
        repeat (4) @(posedge ref_clk);
        outs("rev after hold", 4'h6);
        ev(1'b1, 0, 4);
        wr(OFS_DB_FALL, 8'h00);
    endtask : t_full

    task automatic t_dead();
        int nSys, nDiv, nOsc;
        logic [1:0] early;
        wr(OFS_DB_RISE, 8'h04);
        ctrl(CS_SYS, MD_HALF);
        lag(nSys, early);
        check("dead interval", 32'h00000000, {30'h0, early});
        check("sys lag bound", 32'h00000001, {31'h0, nSys > 2 && nSys < 300});
        ev(1'b1, 0, 4);
        ctrl(CS_DIV4, MD_HALF);
        lag(nDiv, early);
        check("div4 slower", 32'h00000001, {31'h0, nDiv > nSys && nDiv < 300});
        ev(1'b1, 0, 4);
        ctrl(CS_OSC, MD_HALF);
        lag(nOsc, early);
        check("osc slower", 32'h00000001, {31'h0, nOsc > nSys && nOsc < 300});
        ev(1'b1, 0, 8);
        wr(OFS_DB_RISE, 8'h00);
    endtask : t_dead

    task automatic t_rsv();
        for (int m = 6; m < 8; m++) begin
            ctrl(CS_SYS, 3'(m));
            ev(1'b0, 0, 4);
            outs("reserved mode", 4'h0);
        end
        check("leg overlap", 32'h00000000, legFaults);
    endtask : t_rsv

    // ************************************************
    // Sequence and watchdog
    // ************************************************
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_regs();
        t_half();
        t_pp();
        t_full();
        t_dead();
        t_rsv();
        stop_test();
    end

    // The whole sequence needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        stop_test();
    end
endmodule : cogen_top_test
